// ===== robot_cfg_map.svh
`ifndef ROBOT_CFG_MAP_SVH
`define ROBOT_CFG_MAP_SVH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_SWITCH    8'h04
`define OFS_IP        8'h08
`define OFS_MASK      8'h0C
`define OFS_GW        8'h10
`define OFS_IMAGE     8'h14
`define OFS_LEVELS    8'h18
`define OFS_EVENTS    8'h1C
`define OFS_SCALE_IN  8'h20
`define OFS_SCALE_OUT 8'h24

// fixed network settings
`define IP_PREFIX     32'hC0A8_0000
`define NET_MASK      32'hFFFF_FF00
`define GATEWAY       32'h0000_0000

// switch fields, bit 0 is position 1
`define SW_HOST_MSB   5
`define SW_SEL_LSB    6
`define SW_SEL_MSB    7
`define SEL_STANDARD  2'h0
`define SETTLE_CYCLES 4'h3

// robot-to-device image fields, bit 0 is absolute bit 1
`define IMG_START     0
`define IMG_READY     1
`define IMG_MODE_LSB  2
`define IMG_MODE_MSB  6
`define IMG_CMD_LSB   8
`define IMG_CMD_MSB   13
`define IMG_LINE_LSB  14
`define IMG_LINE_MSB  15

// control and scaler fields
`define CTRL_RESTART  0
`define SC_VAL_MSB    15
`define SC_FACT_LSB   16
`define SC_FACT_MSB   23
`define SC_SIGNED     24
`define SINT16_MAX    26'sh000_7FFF
`define SINT16_MIN    -26'sh000_8000
`define UINT16_MAX    26'sh000_FFFF

`endif

// ===== robot_cfg_pkg.sv
package robot_cfg_pkg;
    typedef logic [15:0] uint16_t;
    typedef logic signed [15:0] sint16_t;
    typedef enum logic [2:0] {
        SW_SETTLE  = 3'b001,
        SW_CAPTURE = 3'b010,
        SW_RUN     = 3'b100
    } switch_state_e;
endpackage : robot_cfg_pkg

// ===== switch_capture.sv
`timescale 1ns/1ps
`include "robot_cfg_map.svh"
module switch_capture import robot_cfg_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] dip_on,
    input wire logic restart,
    output logic [7:0] sw_value,
    output logic image_std,
    output logic cfg_ready
);
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    switch_state_e state;
    switch_state_e next_state;
    logic [3:0] settle;
    logic [3:0] next_settle;
    logic [7:0] next_sw_value;
    logic next_image_std;
    logic next_cfg_ready;

    // two-stage synchroniser, switch pins are asynchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 8'h00;
            sync_b <= 8'h00;
        end else begin
            sync_a <= dip_on;
            sync_b <= sync_a;
        end
    end

    // later switch moves ignored until restart
    always_comb begin
        next_state = state;
        next_settle = settle;
        next_sw_value = sw_value;
        next_image_std = image_std;
        next_cfg_ready = cfg_ready;
        case (state)
            SW_SETTLE: begin
                next_settle = settle + 4'h1;
                if (settle == `SETTLE_CYCLES) begin
                    next_state = SW_CAPTURE;
                end
            end
            SW_CAPTURE: begin
                next_sw_value = sync_b;
                // only both select positions off is valid
                next_image_std = (sync_b[`SW_SEL_MSB:`SW_SEL_LSB] == `SEL_STANDARD);
                next_cfg_ready = 1'b1;
                next_state = SW_RUN;
            end
            SW_RUN: begin
                if (restart) begin
                    next_state = SW_SETTLE;
                    next_settle = 4'h0;
                    next_cfg_ready = 1'b0;
                end
            end
            default: begin
                next_state = SW_SETTLE;
                next_settle = 4'h0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SW_SETTLE;
            settle <= 4'h0;
            sw_value <= 8'h00;
            image_std <= 1'b0;
            cfg_ready <= 1'b0;
        end else begin
            state <= next_state;
            settle <= next_settle;
            sw_value <= next_sw_value;
            image_std <= next_image_std;
            cfg_ready <= next_cfg_ready;
        end
    end
endmodule : switch_capture

// ===== image_edges.sv
`timescale 1ns/1ps
module image_edges #(
    parameter int WIDTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic clear,
    input wire logic [WIDTH-1:0] data,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] next_level;
    logic [WIDTH-1:0] next_rise;

    if (WIDTH < 1) begin : g_bad_width
        $error("image_edges needs a width of at least one");
    end

    // per-bit compare against the previous image
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            next_level[i] = level[i];
            next_rise[i] = 1'b0;
            if (clear) begin
                next_level[i] = 1'b0;
            end else if (load) begin
                next_level[i] = data[i];
                next_rise[i] = data[i] & ~level[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= '0;
            rise <= '0;
        end else begin
            level <= next_level;
            rise <= next_rise;
        end
    end
endmodule : image_edges

// ===== robot_bus_switch_config_input_image.sv
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "robot_cfg_map.svh"
module robot_bus_switch_config_input_image import robot_cfg_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] dip_on,
    output logic [31:0] ip_addr,
    output logic [31:0] net_mask,
    output logic [31:0] gateway,
    output logic image_std,
    output logic cfg_ready,
    output logic weld_start,
    output logic robot_ready,
    output logic [4:0] work_mode,
    output logic [5:0] cmd_pulse,
    output logic [1:0] line_sel
);
    logic [7:0] sw_value;
    logic [15:0] img_level;
    logic [15:0] img_rise;
    logic access;
    logic wr_fire;
    logic img_load;
    logic img_clear;
    logic [7:0] offs;
    logic restart;
    logic next_restart;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic [31:0] rd_value;
    logic [31:0] next_ip_addr;
    logic [6:0] events;
    logic [6:0] next_events;
    logic [24:0] scale_in;
    logic [24:0] next_scale_in;
    logic [16:0] scale_out;
    logic [16:0] next_scale_out;

    if (ADDR_W < 8) begin : g_bad_addr
        $error("address bus must be at least 8 bits wide");
    end

    // low byte decides the register, upper bits must be zero
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        if ((a >> 8) == '0) begin
            case (a[7:0])
                `OFS_CTRL, `OFS_SWITCH, `OFS_IP, `OFS_MASK, `OFS_GW,
                `OFS_IMAGE, `OFS_LEVELS, `OFS_EVENTS, `OFS_SCALE_IN,
                `OFS_SCALE_OUT: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction : addr_mapped

    // value times factor, clipped to the chosen word format
    function automatic logic [16:0] scale_word(input logic [24:0] cfg);
        logic signed [16:0] val;
        logic signed [8:0] fact;
        logic signed [25:0] prod;
        logic [16:0] res;
        val = $signed({cfg[`SC_SIGNED] & cfg[`SC_VAL_MSB], cfg[`SC_VAL_MSB:0]});
        fact = $signed({1'b0, cfg[`SC_FACT_MSB:`SC_FACT_LSB]});
        // widen before multiplying so an unsigned full-scale value cannot wrap
        prod = 26'(val) * 26'(fact);
        res = {1'b0, prod[15:0]};
        if (cfg[`SC_SIGNED]) begin
            if (prod > `SINT16_MAX) begin
                res = {1'b1, 16'h7FFF};
            end else if (prod < `SINT16_MIN) begin
                res = {1'b1, 16'h8000};
            end
        end else if (prod > `UINT16_MAX) begin
            res = {1'b1, 16'hFFFF};
        end
        return res;
    endfunction : scale_word

    assign offs = paddr[7:0];
    assign access = psel && penable;
    assign wr_fire = access && pready && pwrite && !pslverr;

    // switch sampling and restart handling
    switch_capture u_switch (
        .pclk(pclk),
        .presetn(presetn),
        .dip_on(dip_on),
        .restart(restart),
        .sw_value(sw_value),
        .image_std(image_std),
        .cfg_ready(cfg_ready)
    );

    // image only taken while a valid standard image is selected
    assign img_load = wr_fire && (offs == `OFS_IMAGE);
    assign img_clear = restart || !cfg_ready || !image_std;

    image_edges #(
        .WIDTH(16)
    ) u_edges (
        .pclk(pclk),
        .presetn(presetn),
        .load(img_load),
        .clear(img_clear),
        .data(pwdata[15:0]),
        .level(img_level),
        .rise(img_rise)
    );

    assign weld_start = img_rise[`IMG_START];
    assign robot_ready = img_level[`IMG_READY];
    assign work_mode = img_level[`IMG_MODE_MSB:`IMG_MODE_LSB];
    // one pulse per rising command bit
    assign cmd_pulse = img_rise[`IMG_CMD_MSB:`IMG_CMD_LSB];
    // process line code, bit 14 low-order
    assign line_sel = img_level[`IMG_LINE_MSB:`IMG_LINE_LSB];

    // read multiplexer
    always_comb begin
        rd_value = 32'h0000_0000;
        case (offs)
            `OFS_CTRL: rd_value = {30'h0, cfg_ready, restart};
            `OFS_SWITCH: rd_value = {22'h0, image_std, cfg_ready, sw_value};
            `OFS_IP: rd_value = ip_addr;
            `OFS_MASK: rd_value = net_mask;
            `OFS_GW: rd_value = gateway;
            `OFS_IMAGE: rd_value = {16'h0, img_level};
            `OFS_LEVELS: rd_value = {24'h0, line_sel, work_mode, robot_ready};
            `OFS_EVENTS: rd_value = {25'h0, events};
            `OFS_SCALE_IN: rd_value = {7'h0, scale_in};
            `OFS_SCALE_OUT: rd_value = {15'h0, scale_out};
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // apb answer: pready in the second access cycle, data latched with it
    always_comb begin
        next_pready = 1'b0;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (access && !pready) begin
            next_pready = 1'b1;
            next_pslverr = !addr_mapped(paddr);
            // image writes refused while no valid image is selected
            if (pwrite && offs == `OFS_IMAGE && (!cfg_ready || !image_std)) begin
                next_pslverr = 1'b1;
            end
            next_prdata = pwrite ? 32'h0000_0000 : (addr_mapped(paddr) ? rd_value : 32'h0);
        end else if (!access) begin
            next_pslverr = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // software restart is a one-cycle pulse
    always_comb begin
        next_restart = 1'b0;
        if (wr_fire && offs == `OFS_CTRL) begin
            next_restart = pwdata[`CTRL_RESTART];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart <= 1'b0;
        end else begin
            restart <= next_restart;
        end
    end

    // address follows the captured switch only
    always_comb begin
        next_ip_addr = ip_addr;
        if (cfg_ready) begin
            // positions 1-6, position 1 as lsb
            // 0..63 appended to the fixed prefix
            next_ip_addr = `IP_PREFIX | {26'h0, sw_value[`SW_HOST_MSB:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ip_addr <= `IP_PREFIX;
            net_mask <= `NET_MASK;
            gateway <= `GATEWAY;
        end else begin
            ip_addr <= next_ip_addr;
            net_mask <= `NET_MASK;
            gateway <= `GATEWAY;
        end
    end

    // sticky edge events, write one to clear; a new edge beats the clear
    always_comb begin
        next_events = events;
        if (wr_fire && offs == `OFS_EVENTS) begin
            next_events = events & ~pwdata[6:0];
        end
        if (img_clear) begin
            next_events = 7'h00;
        end
        next_events = next_events | {img_rise[`IMG_CMD_MSB:`IMG_CMD_LSB], img_rise[`IMG_START]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= 7'h00;
        end else begin
            events <= next_events;
        end
    end

    always_comb begin
        next_scale_in = scale_in;
        if (wr_fire && offs == `OFS_SCALE_IN) begin
            next_scale_in = pwdata[24:0];
        end
        next_scale_out = scale_word(scale_in);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scale_in <= 25'h000_0000;
            scale_out <= 17'h0_0000;
        end else begin
            scale_in <= next_scale_in;
            scale_out <= next_scale_out;
        end
    end
endmodule : robot_bus_switch_config_input_image

// ===== robot_cfg_checker_sva.sv
`timescale 1ns/1ps
`include "robot_cfg_map.svh"
module robot_cfg_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] dip_on,
    input wire logic [31:0] ip_addr,
    input wire logic [31:0] net_mask,
    input wire logic [31:0] gateway,
    input wire logic image_std,
    input wire logic cfg_ready,
    input wire logic weld_start,
    input wire logic robot_ready,
    input wire logic [4:0] work_mode,
    input wire logic [5:0] cmd_pulse,
    input wire logic [1:0] line_sel
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // accepted image write completing this cycle
    logic img_ok;
    assign img_ok = psel && penable && pready && pwrite && !pslverr
        && paddr == ADDR_W'(`OFS_IMAGE);
    a_fixed_net: assert property (net_mask == 32'hFFFF_FF00 && gateway == 32'h0000_0000)
        else $error("mask or gateway wrong");
    a_ip_prefix: assert property (ip_addr[31:6] == 26'h302_A000)
        else $error("ip prefix or host range wrong");
    // dip must sit still long enough to pass the synchroniser
    a_capture_sw: assert property ($rose(cfg_ready) && $past(dip_on, 4) == dip_on |=>
        ip_addr[5:0] == $past(dip_on[5:0]) && image_std == ($past(dip_on[7:6]) == 2'b00))
        else $error("switch capture wrong");
    // ip_addr follows the capture one cycle late, so start watching a cycle later
    a_hold_run: assert property (cfg_ready && $past(cfg_ready, 2) |->
        $stable(ip_addr) && $stable(image_std)) else $error("settings moved while running");
    a_image_off: assert property (!image_std |-> !robot_ready && work_mode == 5'h00
        && line_sel == 2'h0 && !weld_start && cmd_pulse == 6'h00) else $error("bad image live");
    a_levels: assert property ($past(img_ok) |-> robot_ready == $past(pwdata[1])
        && work_mode == $past(pwdata[6:2]) && line_sel == $past(pwdata[15:14]))
        else $error("levels do not follow image");
    a_edge_src: assert property (weld_start || cmd_pulse != 6'h00 |-> $past(img_ok)
        && (!weld_start || $past(pwdata[0])) && (cmd_pulse & ~$past(pwdata[13:8])) == 6'h00)
        else $error("edge without a rising image bit");
    a_pulse_once: assert property (weld_start || cmd_pulse != 6'h00 |=>
        !weld_start && cmd_pulse == 6'h00) else $error("edge pulse longer than one cycle");
    c_start: cover property (weld_start);
    c_cmd: cover property (cmd_pulse != 6'h00);
    c_nonstd: cover property (cfg_ready && !image_std);
endmodule : robot_cfg_checker

bind robot_bus_switch_config_input_image robot_cfg_checker #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .dip_on(dip_on),
    .ip_addr(ip_addr), .net_mask(net_mask), .gateway(gateway), .image_std(image_std),
    .cfg_ready(cfg_ready), .weld_start(weld_start), .robot_ready(robot_ready),
    .work_mode(work_mode), .cmd_pulse(cmd_pulse), .line_sel(line_sel));

// ===== robot_scanner.sv
`timescale 1ns/1ps
module robot_scanner (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'h0000_0000;
    end
    // one apb transfer; held until pready is seen, released lines show garbage
    // image word travels whole in pwdata[15:0]
    // scaled words travel as raw 16-bit patterns
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : robot_scanner

// ===== robot_bus_switch_config_input_image_tb_top.sv
`timescale 1ns/1ps
`include "robot_cfg_map.svh"
module robot_bus_switch_config_input_image_tb_top;
    typedef struct {logic [15:0] img; logic [31:0] lv; logic [31:0] ev;} row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, image_std, cfg_ready;
    logic weld_start, robot_ready;
    logic [7:0] paddr, dip_on;
    logic [31:0] pwdata, prdata, ip_addr, net_mask, gateway;
    logic [4:0] work_mode;
    logic [5:0] cmd_pulse;
    logic [1:0] line_sel;
    int errors = 0;
    int cmp_count = 0;
    row_s rows [6] = '{'{16'h0003, 32'h01, 32'h01}, '{16'h0003, 32'h01, 32'h00},
        '{16'h3F7E, 32'h3F, 32'h7E}, '{16'hC000, 32'hC0, 32'h00},
        '{16'h4100, 32'h40, 32'h02}, '{16'h0080, 32'h00, 32'h00}};
    logic [31:0] sc_in [5] = '{32'h0064_007B, 32'h010A_FFFA, 32'h0002_FFFF, 32'h0102_7FFF,
        32'h0102_8000};
    logic [31:0] sc_out [5] = '{32'h0000_300C, 32'h0000_FFC4, 32'h0001_FFFF, 32'h0001_7FFF,
        32'h0001_8000};

    robot_bus_switch_config_input_image u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dip_on(dip_on), .ip_addr(ip_addr),
        .net_mask(net_mask), .gateway(gateway), .image_std(image_std), .cfg_ready(cfg_ready),
        .weld_start(weld_start), .robot_ready(robot_ready), .work_mode(work_mode),
        .cmd_pulse(cmd_pulse), .line_sel(line_sel));
    robot_scanner u_scan (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] q;
        logic e;
        u_scan.xfer(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
        chk(32'(e), 32'(eexp));
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eexp);
        logic [31:0] q;
        logic e;
        u_scan.xfer(1'b1, a, d, q, e);
        chk(32'(e), 32'(eexp));
    endtask : wr
    // bounded wait for the switch capture to finish
    task automatic wait_cfg;
        int n;
        n = 0;
        while (cfg_ready !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        // ip_addr is registered one cycle after cfg_ready, let it settle
        repeat (2) @(posedge pclk);
        chk(32'(cfg_ready), 32'h1);
    endtask : wait_cfg
    task automatic restart(input logic [7:0] sw);
        dip_on <= sw;
        wr(`OFS_CTRL, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        wait_cfg();
    endtask : restart
    task automatic results;
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // run needs well under 5000 cycles
    initial begin
        #50000;
        errors++;
        results();
    end
    initial begin
        presetn = 1'b0;
        dip_on = 8'h02;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wait_cfg();
        rd(`OFS_IP, 32'hC0A8_0002, 1'b0);
        rd(`OFS_MASK, 32'hFFFF_FF00, 1'b0);
        rd(`OFS_GW, 32'h0000_0000, 1'b0);
        rd(`OFS_SWITCH, 32'h0000_0302, 1'b0);
        // image rows: levels follow, edges latch once
        foreach (rows[i]) begin
            wr(`OFS_IMAGE, 32'(rows[i].img), 1'b0);
            rd(`OFS_LEVELS, rows[i].lv, 1'b0);
            rd(`OFS_EVENTS, rows[i].ev, 1'b0);
            wr(`OFS_EVENTS, 32'h0000_007F, 1'b0);
        end
        // scaled words, clipping at the 16-bit limits
        foreach (sc_in[i]) begin
            wr(`OFS_SCALE_IN, sc_in[i], 1'b0);
            rd(`OFS_SCALE_IN, sc_in[i], 1'b0);
            rd(`OFS_SCALE_OUT, sc_out[i], 1'b0);
        end
        rd(8'h28, 32'h0000_0000, 1'b1);
        // switch move while running is ignored
        dip_on <= 8'h05;
        repeat (10) @(posedge pclk);
        rd(`OFS_IP, 32'hC0A8_0002, 1'b0);
        restart(8'h05);
        chk(ip_addr, 32'hC0A8_0005);
        // unused selections with the top host value
        for (int s = 1; s < 4; s++) begin
            restart({s[1:0], 6'h3F});
            rd(`OFS_SWITCH, {24'h000001, s[1:0], 6'h3F}, 1'b0);
            chk(ip_addr, 32'hC0A8_003F);
            wr(`OFS_IMAGE, 32'h0000_0003, 1'b1);
            rd(`OFS_LEVELS, 32'h0000_0000, 1'b0);
        end
        // power loss and return re-reads the switch
        dip_on <= 8'h21;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(ip_addr, 32'hC0A8_0000);
        chk(net_mask, 32'hFFFF_FF00);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        wait_cfg();
        chk(ip_addr, 32'hC0A8_0021);
        chk(32'(image_std), 32'h1);
        results();
    end
endmodule : robot_bus_switch_config_input_image_tb_top
